//--- hw/mfp_defines.svh
// constants for the motor fault protection block
`ifndef MFP_DEFINES_SVH
`define MFP_DEFINES_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MFP_CLK_MHZ        40
`define MFP_TICK_US        125
`define MFP_TICK_CYCLES    (`MFP_TICK_US * `MFP_CLK_MHZ)
`define MFP_CHARGE_MS      100
`define MFP_CHARGE_CYCLES  (`MFP_CHARGE_MS * 1000 * `MFP_CLK_MHZ)

// ---------------------------------------------------------------
// limits, scaled so that code * scale compares with no rounding
// ---------------------------------------------------------------
`define MFP_CUR_SCALE      24'd100
`define MFP_CUR_HI_LIM     24'd61380
`define MFP_CUR_LO_LIM     24'd40920
`define MFP_VBUS_SCALE     24'd6865
`define MFP_VBUS_OV_LIM    24'd4092000
`define MFP_VBUS_UV_LIM    24'd869550
`define MFP_TEMP_SCALE     24'd5
`define MFP_TEMP_LIM       24'd3069
`define MFP_SPEED_LIM      16'sd2400

// ---------------------------------------------------------------
// fault flag positions and reset values
// ---------------------------------------------------------------
`define MFP_F_OC_SW        0
`define MFP_F_OV           1
`define MFP_F_UV           2
`define MFP_F_OS           3
`define MFP_F_OT           4
`define MFP_F_OC_HW        5
`define MFP_NFLAGS         6
`define MFP_FLAGS_RST      6'h00
`define MFP_PWM_OE_ON      6'h3f

`endif

//--- hw/mfp_pkg.sv
// types shared by the motor fault protection block
package mfp_pkg;
   // power stage sequence
   typedef enum logic [1:0] {
      MFP_ST_IDLE   = 2'b00,
      MFP_ST_CHARGE = 2'b01,
      MFP_ST_RUN    = 2'b10,
      MFP_ST_ESTOP  = 2'b11
   } mfp_state_t;
endpackage : mfp_pkg

//--- hw/mfp_tick.sv
// monitoring period tick generator
`timescale 1ns/10ps
module mfp_tick #(
   parameter int CYCLES = 5000
) (
   input  wire logic i_clock,
   input  wire logic i_rst,
   output logic      o_tick
);
   localparam int W = $clog2(CYCLES);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (CYCLES < 2) begin : g_bad_cycles
      $error("mfp_tick: CYCLES must be at least 2");
   end

   logic [W-1:0] cnt_r;     // cycles since last tick

   // free running counter, one pulse per period
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cnt_r  <= '0;
         o_tick <= 1'b0;
      end else if (cnt_r == W'(CYCLES - 1)) begin
         cnt_r  <= '0;
         o_tick <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + W'(1);
         o_tick <= 1'b0;
      end
   end
endmodule : mfp_tick

//--- hw/mfp_protect.sv
// motor fault protection monitor and power stage sequencer
`timescale 1ns/10ps
`include "mfp_defines.svh"
module mfp_protect #(
   parameter int TICK_CYCLES   = `MFP_TICK_CYCLES,
   parameter int CHARGE_CYCLES = `MFP_CHARGE_CYCLES
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_ext_fault_n,
   input  wire logic [9:0]  i_phase_u_code,
   input  wire logic [9:0]  i_phase_v_code,
   input  wire logic [9:0]  i_phase_w_code,
   input  wire logic [9:0]  i_bus_voltage_code,
   input  wire logic [9:0]  i_temp_code,
   input  wire logic signed [15:0] i_speed_rpm,
   input  wire logic [5:0]  i_pwm,
   input  wire logic        i_start,
   input  wire logic        i_restart,
   input  wire logic        i_clear_flags,
   input  wire logic        i_clear_hiz,
   output logic [5:0]       o_pwm,
   output logic [5:0]       o_pwm_oe,
   output logic             o_hiz,
   output logic             o_estop,
   output logic             o_inrush_gate,
   output logic             o_power_ready,
   output logic [5:0]       o_fault_flags
);
   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   if (CHARGE_CYCLES < 1) begin : g_bad_charge
      $error("mfp_protect: CHARGE_CYCLES must be at least 1");
   end

   // ---------------------------------------------------------------
   // scaled compare helpers
   // ---------------------------------------------------------------
   // code times scale, wide enough for 3ff * 6865
   function automatic logic [23:0] mfp_scale(input logic [9:0] code,
                                             input logic [23:0] k);
      mfp_scale = 24'({14'h0000, code} * k);
   endfunction : mfp_scale

   // current magnitude above 10 A in either direction
   function automatic logic mfp_cur_over(input logic [9:0] code);
      logic [23:0] s;
      s = mfp_scale(code, `MFP_CUR_SCALE);
      mfp_cur_over = (s > `MFP_CUR_HI_LIM) || (s < `MFP_CUR_LO_LIM);
   endfunction : mfp_cur_over

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic        ext_s1_r;     // synchroniser stage one
   logic        ext_s2_r;     // synchroniser stage two
   logic        tick;         // one monitoring period pulse
   logic [5:0]  ev;           // fault events this cycle
   logic        sw_fault;     // any sampled fault event
   logic        hiz_nxt;      // next tristate state
   logic [5:0]  flags_nxt;    // next sticky flags
   logic        restart_ok;   // restart allowed this cycle
   logic        charge_done;  // charge wait complete
   logic [31:0] charge_cnt_r; // charge wait counter
   mfp_pkg::mfp_state_t state_r;
   mfp_pkg::mfp_state_t state_nxt;

   // ---------------------------------------------------------------
   // external fault synchroniser
   // ---------------------------------------------------------------
   // pin is asynchronous, so two flops before use; costs two cycles
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ext_s1_r <= 1'b1;
         ext_s2_r <= 1'b1;
      end else begin
         ext_s1_r <= i_ext_fault_n;
         ext_s2_r <= ext_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // monitoring period
   // ---------------------------------------------------------------
   mfp_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .o_tick  (tick)
   );

   // ---------------------------------------------------------------
   // limit checks
   // ---------------------------------------------------------------
   // sampled checks only look at inputs on the tick
   always_comb begin
      ev = 6'h00;
      if (tick) begin
         ev[`MFP_F_OC_SW] = mfp_cur_over(i_phase_u_code)
                         || mfp_cur_over(i_phase_v_code)
                         || mfp_cur_over(i_phase_w_code);
         ev[`MFP_F_OV] = mfp_scale(i_bus_voltage_code,
                                   `MFP_VBUS_SCALE)
                         > `MFP_VBUS_OV_LIM;
         ev[`MFP_F_UV] = mfp_scale(i_bus_voltage_code,
                                   `MFP_VBUS_SCALE)
                         < `MFP_VBUS_UV_LIM;
         ev[`MFP_F_OS] = (i_speed_rpm > `MFP_SPEED_LIM)
                      || (i_speed_rpm < -`MFP_SPEED_LIM);
         ev[`MFP_F_OT] = mfp_scale(i_temp_code, `MFP_TEMP_SCALE)
                         > `MFP_TEMP_LIM;
      end
      // hardware fault is a level, low means fault
      ev[`MFP_F_OC_HW] = !ext_s2_r;
   end

   assign sw_fault = |ev[`MFP_F_OT:`MFP_F_OC_SW];

   // ---------------------------------------------------------------
   // sticky fault flags
   // ---------------------------------------------------------------
   // set wins over clear so a fault in the clear cycle is kept
   assign flags_nxt = ev | (i_clear_flags ? 6'h00 : o_fault_flags);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_fault_flags <= `MFP_FLAGS_RST;
      end else begin
         o_fault_flags <= flags_nxt;
      end
   end

   // ---------------------------------------------------------------
   // pwm tristate latch
   // ---------------------------------------------------------------
   // no software path can hold this off; only clear releases it
   assign hiz_nxt = !ext_s2_r || (o_hiz && !i_clear_hiz);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_hiz    <= 1'b0;
         o_pwm_oe <= `MFP_PWM_OE_ON;
      end else begin
         o_hiz    <= hiz_nxt;
         o_pwm_oe <= hiz_nxt ? 6'h00 : `MFP_PWM_OE_ON;
      end
   end

   // ---------------------------------------------------------------
   // capacitor charge wait
   // ---------------------------------------------------------------
   assign charge_done = (charge_cnt_r == 32'(CHARGE_CYCLES - 1));

   // counts only while charging, restarts from zero otherwise
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         charge_cnt_r <= 32'h0000_0000;
      end else if (state_r == mfp_pkg::MFP_ST_CHARGE && !charge_done) begin
         charge_cnt_r <= charge_cnt_r + 32'h0000_0001;
      end else if (state_r != mfp_pkg::MFP_ST_CHARGE) begin
         charge_cnt_r <= 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // power stage sequence
   // ---------------------------------------------------------------
   // restart needs every flag clear and the tristate released
   assign restart_ok = i_restart && (flags_nxt == 6'h00) && !hiz_nxt;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         mfp_pkg::MFP_ST_IDLE: begin
            if (i_start) begin
               state_nxt = mfp_pkg::MFP_ST_CHARGE;
            end
         end
         mfp_pkg::MFP_ST_CHARGE: begin
            if (charge_done) begin
               state_nxt = mfp_pkg::MFP_ST_RUN;
            end
         end
         mfp_pkg::MFP_ST_RUN: begin
            if (sw_fault || ev[`MFP_F_OC_HW]) begin
               state_nxt = mfp_pkg::MFP_ST_ESTOP;
            end
         end
         mfp_pkg::MFP_ST_ESTOP: begin
            if (restart_ok) begin
               state_nxt = mfp_pkg::MFP_ST_RUN;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_r <= mfp_pkg::MFP_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   // gate drives follow pwm only while running; stop forces all low
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pwm         <= 6'h00;
         o_estop       <= 1'b0;
         o_inrush_gate <= 1'b0;
         o_power_ready <= 1'b0;
      end else begin
         o_pwm   <= (state_nxt == mfp_pkg::MFP_ST_RUN) ? i_pwm
                                                       : 6'h00;
         o_estop <= (state_nxt == mfp_pkg::MFP_ST_ESTOP);
         // inrush gate stays on once charged, even through a stop
         o_inrush_gate <= (state_nxt == mfp_pkg::MFP_ST_RUN)
                       || (state_nxt == mfp_pkg::MFP_ST_ESTOP);
         o_power_ready <= (state_nxt == mfp_pkg::MFP_ST_RUN);
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_hiz_on_fault;
      @(posedge i_clock) disable iff (i_rst)
         !ext_s2_r |=> (o_pwm_oe == 6'h00) && o_hiz;
   endproperty
   a_hiz_on_fault: assert property (p_hiz_on_fault)
      else $error("pwm pins not tristated after external fault");
   property p_hiz_hold;
      @(posedge i_clock) disable iff (i_rst)
         o_hiz && !i_clear_hiz |=> o_hiz && (o_pwm_oe == 6'h00);
   endproperty
   a_hiz_hold: assert property (p_hiz_hold)
      else $error("tristate released without clear");

   property p_oc;
      @(posedge i_clock) disable iff (i_rst)
         tick && (i_phase_u_code > 10'd613 || i_phase_u_code < 10'd410
               || i_phase_v_code > 10'd613 || i_phase_v_code < 10'd410
               || i_phase_w_code > 10'd613 || i_phase_w_code < 10'd410)
         |=> o_fault_flags[0] && (o_pwm == 6'h00);
   endproperty
   a_oc: assert property (p_oc)
      else $error("overcurrent not flagged");
   property p_ov;
      @(posedge i_clock) disable iff (i_rst)
         tick && (i_bus_voltage_code > 10'd596) |=> o_fault_flags[1];
   endproperty
   a_ov: assert property (p_ov)
      else $error("overvoltage not flagged");
   property p_uv;
      @(posedge i_clock) disable iff (i_rst)
         tick && !i_clear_flags ##1 !$past(o_fault_flags[2])
         |-> o_fault_flags[2] == ($past(i_bus_voltage_code) < 10'd127);
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage flag wrong at the limit");
   property p_os;
      @(posedge i_clock) disable iff (i_rst)
         tick && (i_speed_rpm == 16'sd2400) && !o_fault_flags[3]
         && !i_clear_flags |=> !o_fault_flags[3];
   endproperty
   a_os: assert property (p_os)
      else $error("overspeed raised at exactly the limit");

   property p_ot;
      @(posedge i_clock) disable iff (i_rst)
         tick && (i_temp_code > 10'd613) |=> o_fault_flags[4];
   endproperty
   a_ot: assert property (p_ot)
      else $error("overtemperature not flagged");
   property p_only_on_tick;
      @(posedge i_clock) disable iff (i_rst)
         !tick |=> (o_fault_flags[4:0] & ~$past(o_fault_flags[4:0]))
                   == 5'h00;
   endproperty
   a_only_on_tick: assert property (p_only_on_tick)
      else $error("sampled fault raised off the tick");

   property p_stop_gates;
      @(posedge i_clock) disable iff (i_rst)
         o_estop |-> (o_pwm == 6'h00) && !o_power_ready;
   endproperty
   a_stop_gates: assert property (p_stop_gates)
      else $error("gate drive active during stop");
   property p_stop_hold;
      @(posedge i_clock) disable iff (i_rst)
         o_estop && !i_restart |=> o_estop;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop left without restart");

   property p_charge;
      @(posedge i_clock) disable iff (i_rst)
         $rose(o_inrush_gate) |-> $past(charge_done);
   endproperty
   a_charge: assert property (p_charge)
      else $error("inrush gate on before charge wait");

   c_hiz:     cover property (@(posedge i_clock) disable iff (i_rst)
                              $rose(o_hiz));
   c_estop:   cover property (@(posedge i_clock) disable iff (i_rst)
                              $rose(o_estop));
   c_restart: cover property (@(posedge i_clock) disable iff (i_rst)
                              o_estop ##1 o_power_ready);
   c_run:     cover property (@(posedge i_clock) disable iff (i_rst)
                              $rose(o_power_ready));
endmodule : mfp_protect

//--- verif/mfp_stage_model.sv
// behavioural model of the power stage and its sensing front end
`timescale 1ns/10ps
module mfp_stage_model (
   output logic               o_ext_fault_n,   // active low fault pin
   output logic [9:0]         o_phase_u_code,  // u current code
   output logic [9:0]         o_phase_v_code,  // v current code
   output logic [9:0]         o_phase_w_code,  // w current code
   output logic [9:0]         o_bus_voltage_code, // bus voltage code
   output logic [9:0]         o_temp_code,     // module temperature
   output logic signed [15:0] o_speed_rpm      // computed speed
);
   // --------------------------------------------------------------
   // sensing values
   // --------------------------------------------------------------
   // healthy operating point: 0 A, about 200 V, cool module, 1000 rpm
   task automatic set_nominal();
      o_phase_u_code     = 10'h200;
      o_phase_v_code     = 10'h200;
      o_phase_w_code     = 10'h200;
      o_bus_voltage_code = 10'h12b;
      o_temp_code        = 10'h0c8;
      o_speed_rpm        = 16'sh03e8;
   endtask : set_nominal

   // one channel moved at a time so each cause is seen alone
   task automatic set_code(input int sel, input logic [15:0] v);
      case (sel)
         0: o_phase_u_code = v[9:0];
         1: o_phase_v_code = v[9:0];
         2: o_phase_w_code = v[9:0];
         3: o_bus_voltage_code = v[9:0];
         4: o_temp_code = v[9:0];
         default: o_speed_rpm = v;
      endcase
   endtask : set_code

   // --------------------------------------------------------------
   // external overcurrent detector
   // --------------------------------------------------------------
   // detector reports a fault by pulling the pin low
   task automatic pull_fault(input logic on);
      o_ext_fault_n = ~on;
   endtask : pull_fault

   // pin idles high, no fault
   initial begin
      o_ext_fault_n = 1'b1;
      set_nominal();
   end
endmodule : mfp_stage_model

//--- verif/mfp_protect_tb.sv
// self-checking bench for the motor fault protection block
`timescale 1ns/10ps
module mfp_protect_tb;
   localparam int TICK   = 8;  // shortened monitoring period
   localparam int CHARGE = 10; // shortened charge wait
   logic               i_clock;       // 40 MHz clock
   logic               i_rst;         // sync reset
   logic               i_ext_fault_n; // from model
   logic [9:0]         i_phase_u_code, i_phase_v_code, i_phase_w_code;
   logic [9:0]         i_bus_voltage_code, i_temp_code;
   logic signed [15:0] i_speed_rpm;
   logic [5:0]         i_pwm;         // modulator pattern
   logic               i_start, i_restart, i_clear_flags, i_clear_hiz;
   logic [5:0]         o_pwm, o_pwm_oe, o_fault_flags;
   logic               o_hiz, o_estop, o_inrush_gate, o_power_ready;
   int                 err_total, checks_done, cyc;

   // --------------------------------------------------------------
   // clock, instances, timeout
   // --------------------------------------------------------------
   initial i_clock = 1'b0;
   always #12.5 i_clock = ~i_clock;

   mfp_stage_model u_mfp_stage_model (
      .o_ext_fault_n(i_ext_fault_n), .o_phase_u_code(i_phase_u_code),
      .o_phase_v_code(i_phase_v_code), .o_phase_w_code(i_phase_w_code),
      .o_bus_voltage_code(i_bus_voltage_code),
      .o_temp_code(i_temp_code), .o_speed_rpm(i_speed_rpm));

   mfp_protect #(.TICK_CYCLES(TICK), .CHARGE_CYCLES(CHARGE)) u_mfp_protect (
      .i_clock(i_clock), .i_rst(i_rst), .i_ext_fault_n(i_ext_fault_n),
      .i_phase_u_code(i_phase_u_code), .i_phase_v_code(i_phase_v_code),
      .i_phase_w_code(i_phase_w_code),
      .i_bus_voltage_code(i_bus_voltage_code), .i_temp_code(i_temp_code),
      .i_speed_rpm(i_speed_rpm), .i_pwm(i_pwm), .i_start(i_start),
      .i_restart(i_restart), .i_clear_flags(i_clear_flags),
      .i_clear_hiz(i_clear_hiz), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
      .o_hiz(o_hiz), .o_estop(o_estop), .o_inrush_gate(o_inrush_gate),
      .o_power_ready(o_power_ready), .o_fault_flags(o_fault_flags));

   // whole run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // inputs move and outputs are read at the falling edge
   task automatic step();
      @(negedge i_clock);
   endtask : step

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   // clear and restart in one cycle, restart sees cleared flags
   task automatic recover();
      i_clear_flags = 1'b1;
      i_restart     = 1'b1;
      step();
      i_clear_flags = 1'b0;
      i_restart     = 1'b0;
      chk(o_fault_flags, 16'h0);
      chk(o_estop, 16'h0);
      chk(o_power_ready, 16'h1);
      chk(o_pwm, 16'h2d);
   endtask : recover

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic test_start();
      int n;
      n = 0;
      chk(o_pwm_oe, 16'h3f);
      chk({o_hiz, o_estop, o_inrush_gate, o_power_ready}, 16'h0);
      i_start = 1'b1;
      step();
      i_start = 1'b0;
      while (o_power_ready !== 1'b1 && n < 4 * CHARGE) begin
         step();
         n++;
      end
      // charge state lasts exactly the charge wait, run on the last edge
      chk(n, CHARGE);
      chk(o_inrush_gate, 16'h1);
      chk(o_pwm, 16'h2d);
   endtask : test_start

   // a limit crossing must stop within one period and latch its cause
   task automatic apply_fault(input int sel, input logic [15:0] v,
                              input int fb);
      int n;
      n = 0;
      u_mfp_stage_model.set_code(sel, v);
      while (o_estop !== 1'b1 && n < 3 * TICK) begin
         step();
         n++;
      end
      chk(n >= 1 && n <= TICK, 16'h1);
      chk(o_fault_flags, 16'h1 << fb);
      chk({o_pwm, o_power_ready}, 16'h0);
      chk(o_inrush_gate, 16'h1);
      u_mfp_stage_model.set_nominal();
      repeat (TICK + 2) step();
      chk(o_fault_flags, 16'h1 << fb);
      i_restart = 1'b1;
      step();
      i_restart = 1'b0;
      chk(o_estop, 16'h1);
      recover();
   endtask : apply_fault

   // values right at a limit must not stop the drive
   task automatic no_fault(input int sel, input logic [15:0] v);
      u_mfp_stage_model.set_code(sel, v);
      repeat (2 * TICK + 2) step();
      chk({o_estop, o_fault_flags}, 16'h0);
      u_mfp_stage_model.set_nominal();
   endtask : no_fault

   // pin fault tristates three cycles later and holds until cleared
   task automatic test_ext();
      int n;
      n = 0;
      u_mfp_stage_model.pull_fault(1'b1);
      while (o_hiz !== 1'b1 && n < 10) begin
         step();
         n++;
      end
      chk(n, 16'h3);
      chk(o_pwm_oe, 16'h0);
      chk({o_estop, o_fault_flags}, 16'h60);
      u_mfp_stage_model.pull_fault(1'b0);
      repeat (6) step();
      chk({o_hiz, o_pwm_oe}, 16'h40);
      i_restart = 1'b1;
      step();
      i_restart = 1'b0;
      chk(o_estop, 16'h1);
      i_clear_hiz = 1'b1;
      step();
      i_clear_hiz = 1'b0;
      chk({o_hiz, o_pwm_oe}, 16'h3f);
      recover();
   endtask : test_ext

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      i_rst = 1'b1;
      i_pwm = 6'h2d;
      {i_start, i_restart, i_clear_flags, i_clear_hiz} = 4'h0;
      repeat (10) step();
      i_rst = 1'b0;
      test_start();
      no_fault(0, 16'h265);
      no_fault(3, 16'h07f);
      no_fault(3, 16'h254);
      no_fault(5, 16'h0960);
      no_fault(4, 16'h265);
      apply_fault(0, 16'h266, 0);
      apply_fault(1, 16'h199, 0);
      apply_fault(2, 16'h266, 0);
      apply_fault(3, 16'h255, 1);
      apply_fault(3, 16'h07e, 2);
      apply_fault(5, 16'h0961, 3);
      apply_fault(5, 16'hf69f, 3);
      apply_fault(4, 16'h266, 4);
      test_ext();
      test_done();
   end
endmodule : mfp_protect_tb
